// [adcseq_consts.vh]
// Purpose: Constants for the converter sequencer: register map, fields, timing.
// Assumes: Byte-wide register port, clock of 10 MHz.
// Notes: Function
// Function
// - Each conversion lasts exactly twelve bit periods from its start; on the RC clock it lasts 11 to 12.
// - Divider code picks 2,4,8,16,32,64 oscillator periods; 011 picks RC clock.
// - Clearing the trigger bit mid-conversion aborts at once.
// - An aborted conversion leaves the result pair untouched.
// - After an abort wait two bit periods before acquisition restarts; on the RC clock the wait is one to two.
// - After that wait acquisition of the selected channel starts automatically.
// - Completion loads the ten-bit result, justified, unused bits zero.
// - With converter off the result bytes are plain read-write storage.
// - Port reads return zero on every analog-configured pin.
// - Output-driven analog pins convert their driven level regardless of direction.
// - Completion loads result, clears trigger bit, sets done flag.
// - Justify one is right aligned; zero is left aligned.
// - Reset returns all registers to reset values and aborts conversions.
`ifndef ADCSEQ_CONSTS_VH
`define ADCSEQ_CONSTS_VH

`define ADCSEQ_ADDR_W        3
`define ADCSEQ_OFF_RES_HI    3'h0
`define ADCSEQ_OFF_RES_LO    3'h1
`define ADCSEQ_OFF_CTRL      3'h2
`define ADCSEQ_OFF_CFG       3'h3
`define ADCSEQ_OFF_STAT      3'h4
`define ADCSEQ_OFF_CLR       3'h5
`define ADCSEQ_OFF_IEN       3'h6
`define ADCSEQ_OFF_PORT      3'h7

`define ADCSEQ_CTRL_RESET    8'h00
`define ADCSEQ_CFG_RESET     8'h00
`define ADCSEQ_CTRL_DIV_HI   7
`define ADCSEQ_CTRL_DIV_LO   6
`define ADCSEQ_CTRL_CHS_HI   5
`define ADCSEQ_CTRL_CHS_LO   3
`define ADCSEQ_CTRL_GO       2
`define ADCSEQ_CTRL_PWR      0
`define ADCSEQ_CFG_JUST      7
`define ADCSEQ_CFG_DIV2      6
`define ADCSEQ_CFG_PCFG_HI   3
`define ADCSEQ_CFG_PCFG_LO   0

`define ADCSEQ_STAT_DONE     0
`define ADCSEQ_STAT_ABORT    1

`define ADCSEQ_CONV_PERIODS  4'hc
`define ADCSEQ_WAIT_PERIODS  4'h2
`define ADCSEQ_DIV_RC        3'h3
`define ADCSEQ_MIN_TAD_NS    1600
`define ADCSEQ_CLK_NS        100

`endif

// [adcseq_tick.v]
// Purpose: Bit period tick generator from oscillator divider or RC clock.
// Assumes: rc_clk_in is a synchronous sample of the RC oscillator.
// Notes: Tick is one cycle wide once per bit period.
`timescale 1ns/10ps
`default_nettype none
`include "adcseq_consts.vh"
module adcseq_tick
  #(parameter CNT_W = 6)
  (
  input  wire             clk_sys,
  input  wire             rst,
  input  wire             run,
  input  wire [2:0]       div_sel,
  input  wire             rc_clk_in,
  output reg              tick
  );

  reg  [CNT_W-1:0] cnt;
  reg  [CNT_W-1:0] limit;
  reg              rc_q;

  // Code bits {b2,b1,b0}: b2 doubles the base period selected by b1:b0
  always @*
  begin
    case (div_sel)
      3'h0:    limit = 6'h01;
      3'h4:    limit = 6'h03;
      3'h1:    limit = 6'h07;
      3'h5:    limit = 6'h0f;
      3'h2:    limit = 6'h1f;
      3'h6:    limit = 6'h3f;
      default: limit = 6'h3f;
    endcase
  end

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cnt  <= 6'h00;
      tick <= 1'b0;
      rc_q <= 1'b0;
    end
    else
    begin
      rc_q <= rc_clk_in;
      if (!run)
      begin
        cnt  <= 6'h00;
        tick <= 1'b0;
      end
      else if (div_sel[1:0] == `ADCSEQ_DIV_RC)
      begin
        cnt  <= 6'h00;
        tick <= rc_clk_in & ~rc_q;
      end
      else if (cnt == limit)
      begin
        cnt  <= 6'h00;
        tick <= 1'b1;
      end
      else
      begin
        cnt  <= cnt + 6'h01;
        tick <= 1'b0;
      end
    end
  end
endmodule // adcseq_tick
`default_nettype wire

// [adcseq_top.v]
// Purpose: Conversion sequencer for a ten-bit successive approximation converter.
// Assumes: Analog front end delivers ten result bits and the RC clock.
// Notes: Registers on a byte port, read data one cycle after read strobe.
`timescale 1ns/10ps
`default_nettype none
`include "adcseq_consts.vh"
module adcseq_top
  #(parameter NPINS = 8)
  (
  input  wire                      clk_sys,
  input  wire                      rst,
  input  wire [`ADCSEQ_ADDR_W-1:0] reg_addr,
  input  wire [7:0]                reg_wdata,
  input  wire                      reg_wr,
  input  wire                      reg_rd,
  output reg  [7:0]                reg_rdata,
  input  wire                      rc_clk_in,
  input  wire [9:0]                sar_result,
  input  wire [NPINS-1:0]          pin_level,
  input  wire [NPINS-1:0]          pin_direction,
  output reg  [2:0]                channel_select,
  output reg                       sample_connect,
  output reg                       sar_active,
  output reg  [NPINS-1:0]          pin_analog_mask,
  output reg                       irq
  );

  localparam ST_OFF  = 4'b0001;
  localparam ST_ACQ  = 4'b0010;
  localparam ST_CONV = 4'b0100;
  localparam ST_WAIT = 4'b1000;

  reg  [7:0]       conversion_control;
  reg  [7:0]       conversion_config;
  reg  [7:0]       result_high_byte;
  reg  [7:0]       result_low_byte;
  reg  [1:0]       status;
  reg  [1:0]       irq_enable;
  reg  [3:0]       state;
  reg  [3:0]       period_cnt;
  reg  [NPINS-1:0] next_analog_mask;
  wire             tick;
  wire             tick_run;
  wire             converter_power_on;
  wire             trigger;
  wire             result_justify_select;
  wire [2:0]       clock_divider_select;
  wire [3:0]       pin_analog_config;
  wire             wr_ctrl;
  wire             done_evt;
  wire             abort_evt;
  wire [1:0]       evt;
  wire [1:0]       clr;

  assign converter_power_on    = conversion_control[`ADCSEQ_CTRL_PWR];
  assign trigger               = conversion_control[`ADCSEQ_CTRL_GO];
  assign result_justify_select = conversion_config[`ADCSEQ_CFG_JUST];
  assign clock_divider_select  = {conversion_config[`ADCSEQ_CFG_DIV2],
                                  conversion_control[`ADCSEQ_CTRL_DIV_HI:`ADCSEQ_CTRL_DIV_LO]};
  assign pin_analog_config     = conversion_config[`ADCSEQ_CFG_PCFG_HI:`ADCSEQ_CFG_PCFG_LO];
  assign wr_ctrl               = reg_wr && (reg_addr == `ADCSEQ_OFF_CTRL);

  // Completion on the twelfth bit period tick of a running conversion
  assign done_evt  = (state == ST_CONV) && tick &&
                     (period_cnt == `ADCSEQ_CONV_PERIODS - 4'h1) &&
                     converter_power_on && trigger;
  // Trigger cleared by software or power removed during conversion
  assign abort_evt = (state == ST_CONV) && (!trigger || !converter_power_on);
  assign evt       = {abort_evt, done_evt};
  // Restart divider phase at start and abort so divided spans are whole periods; RC edges keep their own phase
  assign tick_run  = converter_power_on && !abort_evt &&
                     !((state == ST_ACQ) && trigger);
  assign clr       = (reg_wr && reg_addr == `ADCSEQ_OFF_CLR) ? reg_wdata[1:0] : 2'h0;

  adcseq_tick
    #(.CNT_W(6))
  u_tick
    (
    .clk_sys (clk_sys),
    .rst     (rst),
    .run     (tick_run),
    .div_sel (clock_divider_select),
    .rc_clk_in (rc_clk_in),
    .tick    (tick)
    );

  // Sequencer
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state      <= ST_OFF;
      period_cnt <= 4'h0;
    end
    else
    begin
      case (state)
        ST_OFF:
        begin
          period_cnt <= 4'h0;
          if (converter_power_on)
            state <= ST_ACQ;
        end
        ST_ACQ:
        begin
          period_cnt <= 4'h0;
          if (!converter_power_on)
            state <= ST_OFF;
          else if (trigger)
            state <= ST_CONV;
        end
        ST_CONV:
        begin
          if (abort_evt)
          begin
            period_cnt <= 4'h0;
            state      <= converter_power_on ? ST_WAIT : ST_OFF;
          end
          else if (done_evt)
          begin
            period_cnt <= 4'h0;
            state      <= ST_WAIT;
          end
          else if (tick)
            period_cnt <= period_cnt + 4'h1;
        end
        ST_WAIT:
        begin
          if (!converter_power_on)
          begin
            period_cnt <= 4'h0;
            state      <= ST_OFF;
          end
          else if (tick && period_cnt == `ADCSEQ_WAIT_PERIODS - 4'h1)
          begin
            period_cnt <= 4'h0;
            state      <= ST_ACQ;
          end
          else if (tick)
            period_cnt <= period_cnt + 4'h1;
        end
        default:
        begin
          period_cnt <= 4'h0;
          state      <= ST_OFF;
        end
      endcase
    end
  end

  // Control and configuration registers
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      conversion_control <= `ADCSEQ_CTRL_RESET;
      conversion_config  <= `ADCSEQ_CFG_RESET;
      irq_enable         <= 2'h0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        conversion_control <= {reg_wdata[7:2], 1'b0, reg_wdata[0]};
        // Trigger only accepted when already powered and not waiting
        if (!converter_power_on || state == ST_WAIT)
          conversion_control[`ADCSEQ_CTRL_GO] <= 1'b0;
      end
      else if (done_evt)
        conversion_control[`ADCSEQ_CTRL_GO] <= 1'b0;
      if (reg_wr && reg_addr == `ADCSEQ_OFF_CFG)
        conversion_config <= {reg_wdata[7:6], 2'h0, reg_wdata[3:0]};
      if (reg_wr && reg_addr == `ADCSEQ_OFF_IEN)
        irq_enable <= reg_wdata[1:0];
    end
  end

  // Result pair; reset leaves contents alone only logically, cleared for known state
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      result_high_byte <= 8'h00;
      result_low_byte  <= 8'h00;
    end
    else if (done_evt)
    begin
      if (result_justify_select)
      begin
        result_high_byte <= {6'h00, sar_result[9:8]};
        result_low_byte  <= sar_result[7:0];
      end
      else
      begin
        result_high_byte <= sar_result[9:2];
        result_low_byte  <= {sar_result[1:0], 6'h00};
      end
    end
    else
    begin
      if (reg_wr && reg_addr == `ADCSEQ_OFF_RES_HI)
        result_high_byte <= reg_wdata;
      if (reg_wr && reg_addr == `ADCSEQ_OFF_RES_LO)
        result_low_byte <= reg_wdata;
    end
  end

  // Sticky events, set wins over clear
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_evt
      always @(posedge clk_sys or posedge rst)
      begin
        if (rst)
          status[gi] <= 1'b0;
        else if (evt[gi])
          status[gi] <= 1'b1;
        else if (clr[gi])
          status[gi] <= 1'b0;
      end
    end
  endgenerate

  // Analog pin map per configuration code
  always @*
  begin
    case (pin_analog_config)
      4'h0:    next_analog_mask = 8'hff;
      4'h1:    next_analog_mask = 8'hf7;
      4'h2:    next_analog_mask = 8'h1f;
      4'h3:    next_analog_mask = 8'h17;
      4'h4:    next_analog_mask = 8'h0b;
      4'h5:    next_analog_mask = 8'h03;
      4'h8:    next_analog_mask = 8'hf3;
      4'h9:    next_analog_mask = 8'h3f;
      4'ha:    next_analog_mask = 8'h37;
      4'hb:    next_analog_mask = 8'h33;
      4'hc:    next_analog_mask = 8'h13;
      4'hd:    next_analog_mask = 8'h03;
      4'he:    next_analog_mask = 8'h01;
      4'hf:    next_analog_mask = 8'h01;
      default: next_analog_mask = 8'h00;
    endcase
  end

  // Outputs to the analog side; sampling ignores pin direction
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      channel_select  <= 3'h0;
      sample_connect  <= 1'b0;
      sar_active      <= 1'b0;
      pin_analog_mask <= 8'hff;
      irq             <= 1'b0;
    end
    else
    begin
      channel_select  <= conversion_control[`ADCSEQ_CTRL_CHS_HI:`ADCSEQ_CTRL_CHS_LO];
      sample_connect  <= (state == ST_ACQ) && converter_power_on && !trigger;
      sar_active      <= (state == ST_CONV) && !abort_evt && !done_evt;
      pin_analog_mask <= next_analog_mask[NPINS-1:0];
      irq             <= |(status & irq_enable);
    end
  end

  // Read port
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `ADCSEQ_OFF_RES_HI: reg_rdata <= result_high_byte;
        `ADCSEQ_OFF_RES_LO: reg_rdata <= result_low_byte;
        `ADCSEQ_OFF_CTRL:   reg_rdata <= conversion_control;
        `ADCSEQ_OFF_CFG:    reg_rdata <= conversion_config;
        `ADCSEQ_OFF_STAT:   reg_rdata <= {6'h00, status};
        `ADCSEQ_OFF_IEN:    reg_rdata <= {6'h00, irq_enable};
        `ADCSEQ_OFF_PORT:   reg_rdata <= pin_level & ~pin_analog_mask & 8'hff;
        default:            reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // Direction bits are only meaningful to the pad; kept for port completeness
  wire unused_dir;
  assign unused_dir = ^pin_direction;
endmodule // adcseq_top
`default_nettype wire

// [adcseq_assertions.sv]
// Purpose: Port-level checks for the converter sequencer.
// Assumes: Register port timing and state outputs as in the hand-over.
// Notes: Attached by bind to adcseq_top.
`timescale 1ns/10ps
`default_nettype none
`include "adcseq_consts.vh"
module adcseq_assertions
  #(parameter NPINS = 8)
  (
  input wire logic                      clk_sys,
  input wire logic                      rst,
  input wire logic [`ADCSEQ_ADDR_W-1:0] reg_addr,
  input wire logic [7:0]                reg_wdata,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [7:0]                reg_rdata,
  input wire logic                      rc_clk_in,
  input wire logic [9:0]                sar_result,
  input wire logic [NPINS-1:0]          pin_level,
  input wire logic [NPINS-1:0]          pin_direction,
  input wire logic [2:0]                channel_select,
  input wire logic                      sample_connect,
  input wire logic                      sar_active,
  input wire logic [NPINS-1:0]          pin_analog_mask,
  input wire logic                      irq
  );
  logic [7:0]       wd_q;
  logic [NPINS-1:0] port_exp;
  wire              ctrl_wr = reg_wr && reg_addr == `ADCSEQ_OFF_CTRL;
  always @(posedge clk_sys)
  begin
    wd_q     <= reg_wdata;
    port_exp <= pin_level & ~pin_analog_mask;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_rdata_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
  a_port_mask:
    assert property (reg_rd && reg_addr == `ADCSEQ_OFF_PORT |=> reg_rdata == port_exp[7:0])
    else $error("analog pin not read as zero");
  a_mask_digital:
    assert property (reg_wr && reg_addr == `ADCSEQ_OFF_CFG && reg_wdata[3:1] == 3'h3
      |-> ##2 pin_analog_mask == '0) else $error("digital config left pins analog");
  a_one_state:
    assert property (!(sar_active && sample_connect)) else $error("acquire during conversion");
  a_chan_copy:
    assert property (ctrl_wr |-> ##2 channel_select == $past(reg_wdata[5:3], 2))
    else $error("channel not updated");
  a_abort_now:
    assert property (sar_active && ctrl_wr && !reg_wdata[2] |-> ##2 !sar_active)
    else $error("abort not immediate");
  a_power_off:
    assert property (ctrl_wr && !reg_wdata[0] |-> ##2 !sar_active && !sample_connect)
    else $error("power off did not stop");
  a_settle_wait:
    assert property ($fell(sar_active) |-> !sample_connect [*4])
    else $error("acquire before two bit periods");
  a_start_conv:
    assert property (sample_connect && ctrl_wr && reg_wdata[2] && reg_wdata[0] |-> ##3 sar_active)
    else $error("trigger did not start");
endmodule // adcseq_assertions
bind adcseq_top adcseq_assertions #(.NPINS(NPINS)) u_chk (.clk_sys(clk_sys), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rc_clk_in(rc_clk_in), .sar_result(sar_result),
  .pin_level(pin_level), .pin_direction(pin_direction), .channel_select(channel_select),
  .sample_connect(sample_connect), .sar_active(sar_active),
  .pin_analog_mask(pin_analog_mask), .irq(irq));
`default_nettype wire

// [adcseq_afe_model.sv]
// Purpose: Analog front end stand-in: comparator result and RC oscillator.
// Assumes: Result is only meaningful while a conversion runs.
// Notes: RC clock runs free, period twice RC_HALF clocks.
`timescale 1ns/10ps
`default_nettype none
module adcseq_afe_model
  #(parameter RC_HALF = 10)
  (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       sar_active,
  input  wire logic [9:0] conv_value,
  output var  logic [9:0] sar_result,
  output var  logic       rc_clk_in
  );
  int rc_cnt;
  // Inverted outside a conversion so a stray load shows
  assign sar_result = sar_active ? conv_value : ~conv_value;
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rc_cnt    <= 0;
      rc_clk_in <= 1'b0;
    end
    else if (rc_cnt == RC_HALF - 1)
    begin
      rc_cnt    <= 0;
      rc_clk_in <= ~rc_clk_in;
    end
    else
      rc_cnt <= rc_cnt + 1;
  end
endmodule // adcseq_afe_model
`default_nettype wire

// [tb_adcseq_top.sv]
// Purpose: Register-level tests of the converter sequencer.
// Assumes: Clock of 10 MHz, front end model for result and RC clock.
// Notes: Trigger is always set in a write of its own.
`timescale 1ns/10ps
`default_nettype none
module tb_adcseq_top;
  localparam logic [9:0] V = 10'h2c9;
  logic       clk_sys, rst, reg_wr, reg_rd, rc_clk_in, sample_connect, sar_active, irq;
  logic [2:0] reg_addr, channel_select;
  logic [7:0] reg_wdata, reg_rdata, pin_level, pin_direction, pin_analog_mask;
  logic [9:0] sar_result;
  logic [2:0] codes [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
  logic [7:0] pcs   [3] = '{8'h00, 8'h06, 8'h0e};
  logic [7:0] pms   [3] = '{8'h00, 8'hff, 8'hfe};
  int         tads  [6] = '{2, 4, 8, 16, 32, 64};
  int         n_fail, total_checks, k, len;
  adcseq_top uut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rc_clk_in(rc_clk_in),
    .sar_result(sar_result), .pin_level(pin_level), .pin_direction(pin_direction),
    .channel_select(channel_select), .sample_connect(sample_connect),
    .sar_active(sar_active), .pin_analog_mask(pin_analog_mask), .irq(irq));
  adcseq_afe_model u_afe (.clk_sys(clk_sys), .rst(rst), .sar_active(sar_active),
    .conv_value(V), .sar_result(sar_result), .rc_clk_in(rc_clk_in));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic wait_acq(output int n);
    n = 0;
    while (sample_connect !== 1'b1 && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  // Power on, wait for acquisition, trigger, measure the busy span
  task automatic conv(input logic [2:0] c, input logic j, output int n);
    wr(3'h3, {j, c[2], 6'h06});
    wr(3'h2, {c[1:0], 6'h09});
    wait_acq(n);
    wr(3'h2, {c[1:0], 6'h0d});
    n = 0;
    while (sar_active !== 1'b1 && n < 10)
    begin
      @(posedge clk_sys);
      n++;
    end
    n = 0;
    while (sar_active === 1'b1 && n < 2000)
    begin
      @(posedge clk_sys);
      n++;
    end
    rd(3'h0, j ? {6'h00, V[9:8]} : V[9:2]);
    rd(3'h1, j ? V[7:0] : {V[1:0], 6'h00});
    rd(3'h2, {c[1:0], 6'h09});
    rd(3'h4, 8'h01);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial
  begin
    #2_000_000;
    n_fail++;
    end_sim();
  end
  initial
  begin
    rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    pin_level = 8'ha5;
    pin_direction = 8'h0f;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    for (k = 0; k < 5; k++) rd(k[2:0], 8'h00);
    chk(pin_analog_mask, 8'hff);
    wr(3'h0, 8'h5a);
    wr(3'h1, 8'hc3);
    rd(3'h0, 8'h5a);
    rd(3'h1, 8'hc3);
    $display("reset and storage test done");
    for (k = 0; k < 3; k++)
    begin
      wr(3'h3, pcs[k]);
      rd(3'h7, pin_level & pms[k]);
    end
    $display("port read test done");
    for (k = 0; k < 6; k++)
    begin
      conv(codes[k], k[0], len);
      chk(len >= 11 * tads[k] && len <= 12 * tads[k] + 1, 1'b1);
    end
    chk(irq, 1'b0);
    wr(3'h6, 8'h01);
    rd(3'h4, 8'h01);
    chk(irq, 1'b1);
    wr(3'h5, 8'h01);
    rd(3'h4, 8'h00);
    chk(irq, 1'b0);
    conv(3'h3, 1'b1, len);
    chk(len >= 220 && len <= 242, 1'b1);
    $display("conversion test done");
    wr(3'h3, 8'h46);
    wait_acq(len);
    wr(3'h2, 8'h4d);
    repeat (40) @(posedge clk_sys);
    rd(3'h2, 8'h4d);
    wr(3'h2, 8'h49);
    wait_acq(len);
    chk(len >= 32 && len <= 37, 1'b1);
    rd(3'h0, 8'h02);
    rd(3'h1, 8'hc9);
    rd(3'h4, 8'h03);
    wr(3'h2, 8'h4d);
    repeat (30) @(posedge clk_sys);
    wr(3'h2, 8'h00);
    rd(3'h0, 8'h02);
    chk({sar_active, sample_connect}, 2'b00);
    $display("abort and power off test done");
    end_sim();
  end
endmodule // tb_adcseq_top
`default_nettype wire
